/* File: inc/iopc_consts.svh */
// register offsets, field positions and reset values of the pin control block
`ifndef IOPC_CONSTS_SVH
`define IOPC_CONSTS_SVH

// io-control register offsets
`define IOPC_OFS_PA_DIR      8'hF5
`define IOPC_OFS_PB_DIR      8'hF6
`define IOPC_OFS_PA_UPPER    8'hF8
`define IOPC_OFS_PB_CHG_EN   8'hF9
`define IOPC_OFS_PULL_DOWN   8'hFB
`define IOPC_OFS_OPEN_DRAIN  8'hFC
`define IOPC_OFS_SYS_CTRL    8'hFE
`define IOPC_OFS_IRQ_MASK    8'hFF

// field positions
`define IOPC_BIT_PH_A4       0
`define IOPC_BIT_PH_A6       1
`define IOPC_BIT_PH_A7       2
`define IOPC_BIT_PD_A5       3
`define IOPC_BIT_CHG_FLAG    1
`define IOPC_BIT_EXT_FLAG    2
`define IOPC_BIT_EDGE_SEL    7
`define IOPC_BIT_PIN_SEL     6

// reset values
`define IOPC_RST_DIR         8'hFF
`define IOPC_RST_PULL        8'hFF
`define IOPC_RST_PULL_NIB    4'hF
`define IOPC_RST_ZERO        8'h00
`define IOPC_RST_BIT         1'h0

`endif

/* File: inc/iopc_pkg.sv */
// types shared by the pin control block
package iopc_pkg;
  typedef logic [7:0] iopc_byte_type;
  typedef logic [3:0] iopc_nib_type;
endpackage

/* File: inc/iopc_evt_if.sv */
// carrier between the pin control core and its event detector
`timescale 1ns/1ps
interface iopc_evt_if;
  logic [7:0] pins;      // port b pin levels
  logic [7:0] chg_en;    // per-pin change enables
  logic       edge_sel;  // 1 rising, 0 falling
  logic       ext_sel;   // pb0 acts as interrupt pin
  logic       chg_evt;   // enabled pin changed
  logic       ext_evt;   // selected edge seen on pb0
  modport det  (input pins, chg_en, edge_sel, ext_sel,
                output chg_evt, ext_evt);
  modport core (output pins, chg_en, edge_sel, ext_sel,
                input chg_evt, ext_evt);
endinterface

/* File: rtl/iopc_evt_detect.sv */
// port b change and external pin edge detector
`timescale 1ns/1ps
`include "iopc_consts.svh"
module iopc_evt_detect
  import iopc_pkg::*;
(
  input  wire logic i_mclk,  // instruction clock
  input  wire logic i_rstn,  // async reset, active low
  iopc_evt_if.det   evt      // detector side of carrier
);
  // ==========================================================
  // previous sample of the pins
  iopc_byte_type prev_reg;
  iopc_byte_type prev_next;
  logic          armed_reg;
  logic          armed_next;

  // pins already synchronous; one stage of history is enough
  always_comb begin
    prev_next  = evt.pins;
    armed_next = 1'b1;
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      prev_reg  <= `IOPC_RST_ZERO;
      armed_reg <= `IOPC_RST_BIT;
    end else begin
      prev_reg  <= prev_next;
      armed_reg <= armed_next;
    end
  end

  // ==========================================================
  // event decode; first cycle after reset has no history
  always_comb begin
    evt.chg_evt = armed_reg &
                  (|((evt.pins ^ prev_reg) & evt.chg_en));
    evt.ext_evt = armed_reg & evt.ext_sel &
                  (evt.edge_sel ? (evt.pins[0] & ~prev_reg[0])
                                : (~evt.pins[0] & prev_reg[0]));
  end

  a_rise_detect: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    armed_reg && evt.ext_sel && evt.edge_sel && $rose(evt.pins[0])
    |-> evt.ext_evt) else $error("rising edge missed");
  a_fall_detect: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    evt.ext_evt && !evt.edge_sel |-> $fell(evt.pins[0]))
    else $error("falling event without fall");
endmodule

/* File: rtl/iopc_top.sv */
// pin configuration for ports a and b, input event flags for port b
`timescale 1ns/1ps
`include "iopc_consts.svh"

module iopc_top
  import iopc_pkg::*;
(
  input  wire logic       i_mclk,            // instruction clock
  input  wire logic       i_rstn,            // async reset, active low
  input  wire logic       i_ioc_wr,          // io-control write strobe
  input  wire logic       i_ioc_rd,          // io-control read strobe
  input  wire logic [7:0] i_ioc_addr,        // io-control register offset
  input  wire logic [7:0] i_ioc_wdata,       // io-control write data
  output logic      [7:0] o_ioc_rdata,       // io-control read data
  input  wire logic       i_tmode_wr,        // timer mode register write
  input  wire logic [7:0] i_tmode_wdata,     // timer mode write data
  input  wire logic       i_isr_wr,          // status register write
  input  wire logic [7:0] i_isr_wdata,       // zero bits clear flags
  input  wire logic [7:0] i_pb_pins,         // port b pad levels
  input  wire logic [7:0] i_pb_dout,         // port b output data
  output logic      [7:0] o_pa_dir,          // 1 input, 0 output
  output logic      [7:0] o_pb_dir,          // 1 input, 0 output
  output logic      [7:0] o_pb_oe,           // port b pad drive enable
  output logic            o_pullhigh_n_a4,   // low enables pull-high
  output logic            o_pullhigh_n_a6,   // low enables pull-high
  output logic            o_pullhigh_n_a7,   // low enables pull-high
  output logic            o_pulldown_n_a5,   // low enables pull-down
  output logic      [3:0] o_pa_pulldown_n,   // a0..a3, low enables
  output logic      [3:0] o_pb_pulldown_n,   // b0..b3, low enables
  output logic      [7:0] o_pb_opendrain_en, // 1 open-drain
  output logic            o_ext_edge_select, // 1 rising, 0 falling
  output logic            o_ext_irq_pin_select, // pb0 is interrupt pin
  output logic      [7:0] o_isr_flags,       // status bits 1 and 2
  output logic            o_irq_req          // masked request to core
);
  // ==========================================================
  // register storage
  iopc_byte_type pa_dir_reg,   pa_dir_next;
  iopc_byte_type pb_dir_reg,   pb_dir_next;
  iopc_nib_type  pa_upper_reg, pa_upper_next;
  iopc_byte_type chg_en_reg,   chg_en_next;
  iopc_byte_type pull_dn_reg,  pull_dn_next;
  iopc_byte_type od_reg,       od_next;
  logic          pin_sel_reg,  pin_sel_next;
  logic          edge_reg,     edge_next;
  logic          port_b_change_mask_reg, port_b_change_mask_next;
  logic          ext_pin_irq_mask_reg,   ext_pin_irq_mask_next;
  logic          port_b_change_flag_reg, port_b_change_flag_next;
  logic          ext_pin_irq_flag_reg,   ext_pin_irq_flag_next;
  iopc_byte_type rdata_reg,    rdata_next;
  iopc_byte_type pb_oe_reg,    pb_oe_next;
  logic          irq_reg,      irq_next;

  iopc_evt_if evt ();

  // offset decode used by both write and read paths
  function automatic logic hit(input logic [7:0] addr,
                               input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction

  // ==========================================================
  // event detector
  assign evt.pins     = i_pb_pins;
  assign evt.chg_en   = chg_en_reg;
  assign evt.edge_sel = edge_reg;
  assign evt.ext_sel  = pin_sel_reg;

  iopc_evt_detect u_detect (
    .i_mclk (i_mclk),
    .i_rstn (i_rstn),
    .evt    (evt)
  );

  // ==========================================================
  // configuration registers, io-control writes
  always_comb begin
    pa_dir_next   = pa_dir_reg;
    pb_dir_next   = pb_dir_reg;
    pa_upper_next = pa_upper_reg;
    chg_en_next   = chg_en_reg;
    pull_dn_next  = pull_dn_reg;
    od_next       = od_reg;
    pin_sel_next  = pin_sel_reg;
    edge_next     = edge_reg;
    port_b_change_mask_next = port_b_change_mask_reg;
    ext_pin_irq_mask_next   = ext_pin_irq_mask_reg;
    if (i_ioc_wr) begin
      if (hit(i_ioc_addr, `IOPC_OFS_PA_DIR))
        pa_dir_next = i_ioc_wdata;
      if (hit(i_ioc_addr, `IOPC_OFS_PB_DIR))
        pb_dir_next = i_ioc_wdata;
      if (hit(i_ioc_addr, `IOPC_OFS_PA_UPPER))
        pa_upper_next = i_ioc_wdata[3:0];
      if (hit(i_ioc_addr, `IOPC_OFS_PB_CHG_EN))
        chg_en_next = i_ioc_wdata;
      if (hit(i_ioc_addr, `IOPC_OFS_PULL_DOWN))
        pull_dn_next = i_ioc_wdata;
      if (hit(i_ioc_addr, `IOPC_OFS_OPEN_DRAIN))
        od_next = i_ioc_wdata;
      if (hit(i_ioc_addr, `IOPC_OFS_SYS_CTRL))
        pin_sel_next = i_ioc_wdata[`IOPC_BIT_PIN_SEL];
      if (hit(i_ioc_addr, `IOPC_OFS_IRQ_MASK)) begin
        port_b_change_mask_next = i_ioc_wdata[`IOPC_BIT_CHG_FLAG];
        ext_pin_irq_mask_next   = i_ioc_wdata[`IOPC_BIT_EXT_FLAG];
      end
    end
    // only the edge bit of the timer mode register lives here
    if (i_tmode_wr)
      edge_next = i_tmode_wdata[`IOPC_BIT_EDGE_SEL];
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      pa_dir_reg   <= `IOPC_RST_DIR;
      pb_dir_reg   <= `IOPC_RST_DIR;
      pa_upper_reg <= `IOPC_RST_PULL_NIB;
      chg_en_reg   <= `IOPC_RST_ZERO;
      pull_dn_reg  <= `IOPC_RST_PULL;
      od_reg       <= `IOPC_RST_ZERO;
      pin_sel_reg  <= `IOPC_RST_BIT;
      edge_reg     <= `IOPC_RST_BIT;
      port_b_change_mask_reg <= `IOPC_RST_BIT;
      ext_pin_irq_mask_reg   <= `IOPC_RST_BIT;
    end else begin
      pa_dir_reg   <= pa_dir_next;
      pb_dir_reg   <= pb_dir_next;
      pa_upper_reg <= pa_upper_next;
      chg_en_reg   <= chg_en_next;
      pull_dn_reg  <= pull_dn_next;
      od_reg       <= od_next;
      pin_sel_reg  <= pin_sel_next;
      edge_reg     <= edge_next;
      port_b_change_mask_reg <= port_b_change_mask_next;
      ext_pin_irq_mask_reg   <= ext_pin_irq_mask_next;
    end
  end

  // ==========================================================
  // sticky flags; a new event beats a clear in the same cycle
  always_comb begin
    port_b_change_flag_next = port_b_change_flag_reg;
    ext_pin_irq_flag_next   = ext_pin_irq_flag_reg;
    if (i_isr_wr) begin
      port_b_change_flag_next = port_b_change_flag_reg &
                                i_isr_wdata[`IOPC_BIT_CHG_FLAG];
      ext_pin_irq_flag_next   = ext_pin_irq_flag_reg &
                                i_isr_wdata[`IOPC_BIT_EXT_FLAG];
    end
    if (evt.chg_evt)
      port_b_change_flag_next = 1'b1;
    if (evt.ext_evt)
      ext_pin_irq_flag_next = 1'b1;
    // request follows the flag in the same edge, mask applied
    irq_next = (port_b_change_flag_next & port_b_change_mask_next) |
               (ext_pin_irq_flag_next & ext_pin_irq_mask_next);
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      port_b_change_flag_reg <= `IOPC_RST_BIT;
      ext_pin_irq_flag_reg   <= `IOPC_RST_BIT;
      irq_reg                <= `IOPC_RST_BIT;
    end else begin
      port_b_change_flag_reg <= port_b_change_flag_next;
      ext_pin_irq_flag_reg   <= ext_pin_irq_flag_next;
      irq_reg                <= irq_next;
    end
  end

  // ==========================================================
  // pad drive enable and read-back
  always_comb begin
    // output mode drives; open-drain drives only for a zero;
    // pb0 never drives while it is the interrupt input
    pb_oe_next = ~pb_dir_next & ~(od_next & i_pb_dout);
    if (pin_sel_next)
      pb_oe_next[0] = 1'b0;
    rdata_next = rdata_reg;
    if (i_ioc_rd) begin
      rdata_next = `IOPC_RST_ZERO;                  // unmapped reads zero
      if (hit(i_ioc_addr, `IOPC_OFS_PA_DIR))     rdata_next = pa_dir_reg;
      if (hit(i_ioc_addr, `IOPC_OFS_PB_DIR))     rdata_next = pb_dir_reg;
      if (hit(i_ioc_addr, `IOPC_OFS_PA_UPPER))
        rdata_next = {4'h0, pa_upper_reg};
      if (hit(i_ioc_addr, `IOPC_OFS_PB_CHG_EN))  rdata_next = chg_en_reg;
      if (hit(i_ioc_addr, `IOPC_OFS_PULL_DOWN))  rdata_next = pull_dn_reg;
      if (hit(i_ioc_addr, `IOPC_OFS_OPEN_DRAIN)) rdata_next = od_reg;
      if (hit(i_ioc_addr, `IOPC_OFS_SYS_CTRL))
        rdata_next = {1'b0, pin_sel_reg, 6'h00};
      if (hit(i_ioc_addr, `IOPC_OFS_IRQ_MASK))
        rdata_next = {5'h00, ext_pin_irq_mask_reg,
                      port_b_change_mask_reg, 1'b0};
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      pb_oe_reg <= `IOPC_RST_ZERO;
      rdata_reg <= `IOPC_RST_ZERO;
    end else begin
      pb_oe_reg <= pb_oe_next;
      rdata_reg <= rdata_next;
    end
  end

  // ==========================================================
  // outputs, all straight from flops
  assign o_ioc_rdata          = rdata_reg;
  assign o_pa_dir             = pa_dir_reg;
  assign o_pb_dir             = pb_dir_reg;
  assign o_pb_oe              = pb_oe_reg;
  assign o_pullhigh_n_a4      = pa_upper_reg[`IOPC_BIT_PH_A4];
  assign o_pullhigh_n_a6      = pa_upper_reg[`IOPC_BIT_PH_A6];
  assign o_pullhigh_n_a7      = pa_upper_reg[`IOPC_BIT_PH_A7];
  assign o_pulldown_n_a5      = pa_upper_reg[`IOPC_BIT_PD_A5];
  assign o_pa_pulldown_n      = pull_dn_reg[3:0];
  assign o_pb_pulldown_n      = pull_dn_reg[7:4];
  assign o_pb_opendrain_en    = od_reg;
  assign o_ext_edge_select    = edge_reg;
  assign o_ext_irq_pin_select = pin_sel_reg;
  assign o_isr_flags          = {5'h00, ext_pin_irq_flag_reg,
                                 port_b_change_flag_reg, 1'b0};
  assign o_irq_req            = irq_reg;

  // ==========================================================
  // checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);

  sequence s_pb_toggle;
    |((i_pb_pins ^ $past(i_pb_pins)) & chg_en_reg);
  endsequence
  sequence s_flag_clear_try;
    i_isr_wr && !i_isr_wdata[`IOPC_BIT_CHG_FLAG];
  endsequence

  a_chg_flag_set: assert property (s_pb_toggle ##1 1'b1
    |-> o_isr_flags[`IOPC_BIT_CHG_FLAG]) else $error("change flag not set");
  a_set_beats_clr: assert property (s_flag_clear_try and evt.chg_evt
    |=> o_isr_flags[`IOPC_BIT_CHG_FLAG]) else $error("set lost to clear");
  a_flag_sticky: assert property (o_isr_flags[`IOPC_BIT_EXT_FLAG] &&
    !i_isr_wr |=> o_isr_flags[`IOPC_BIT_EXT_FLAG])
    else $error("ext flag dropped");
  a_ext_flag_set: assert property (evt.ext_evt
    |=> o_isr_flags[`IOPC_BIT_EXT_FLAG]) else $error("ext flag not set");
  a_dir_write: assert property (i_ioc_wr && i_ioc_addr == `IOPC_OFS_PA_DIR
    |=> o_pa_dir == $past(i_ioc_wdata)) else $error("pa dir not written");
  a_od_low_only: assert property ($past(od_reg[3] & od_next[3]) &&
    $past(i_pb_dout[3]) |-> !o_pb_oe[3]) else $error("od drove high");
  a_pb0_input: assert property (o_ext_irq_pin_select |-> !o_pb_oe[0])
    else $error("pb0 driven as int pin");
  a_irq_gate: assert property (o_irq_req |-> (o_isr_flags[1] &&
    port_b_change_mask_reg) || (o_isr_flags[2] && ext_pin_irq_mask_reg))
    else $error("unmasked request");
  a_pull_write: assert property (i_ioc_wr &&
    i_ioc_addr == `IOPC_OFS_PULL_DOWN |=> o_pb_pulldown_n ==
    $past(i_ioc_wdata[7:4])) else $error("pull-down late");
endmodule

/* File: test/iopc_pin_model.sv */
// board-side model of the port b pads: drivers, pull-downs, floating pins
`timescale 1ns/1ps
module iopc_pin_model (
  input  wire logic       i_mclk,    // instruction clock
  input  wire logic [7:0] i_oe,      // pad drive enable from block
  input  wire logic [7:0] i_dout,    // output latch value
  input  wire logic [3:0] i_pd_n,    // b0..b3 pull-down, low on
  input  wire logic [7:0] i_ext_en,  // board drives the pin
  input  wire logic [7:0] i_ext_val, // board level
  output logic      [7:0] o_pins     // pad levels seen by block
);
  logic [7:0] pins_next;
  logic [7:0] last_reg;
  logic [7:0] last_next;
  // resolve each pad; a floating pin flips so stale levels never pass
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      last_next[k] = last_reg[k];
      if (i_oe[k]) begin
        pins_next[k] = i_dout[k];
        last_next[k] = i_dout[k];
      end else if (i_ext_en[k]) begin
        pins_next[k] = i_ext_val[k];
        last_next[k] = i_ext_val[k];
      end else if ((k < 4) && !i_pd_n[k[1:0]]) begin
        pins_next[k] = 1'h0;
      end else begin
        pins_next[k] = ~last_reg[k];
      end
    end
  end
  // pads settle synchronously to the instruction clock
  always_ff @(posedge i_mclk) begin
    o_pins   <= pins_next;
    last_reg <= last_next;
  end
endmodule

/* File: test/iopc_top_tb.sv */
// self-checking bench for the port pin control block
`timescale 1ns/1ps
module iopc_top_tb;
  logic       i_mclk = 1'h0;
  logic       i_rstn = 1'h0;
  logic       ioc_wr = 1'h0;
  logic       ioc_rd = 1'h0;
  logic       tm_wr  = 1'h0;
  logic       isr_wr = 1'h0;
  logic [7:0] addr   = 8'h00;
  logic [7:0] wdata  = 8'h00;
  logic [7:0] dout   = 8'h00;
  logic [7:0] ext_val = 8'h00;
  logic [7:0] rdata, pa_dir, pb_dir, pb_oe, pins, od, flags;
  logic       ph4, ph6, ph7, pd5, eds, eps, irq;
  logic [3:0] pad_n, pbd_n;
  int         err_total = 0;
  int         checked = 0;
  logic [7:0] ta  [6] = '{8'hF5, 8'hF6, 8'hF8, 8'hF9, 8'hFB, 8'hFC};
  logic [7:0] td  [6] = '{8'h3C, 8'hA5, 8'hFA, 8'h5A, 8'hC3, 8'h96};
  logic [7:0] tr  [6] = '{8'h3C, 8'hA5, 8'h0A, 8'h5A, 8'hC3, 8'h96};
  logic [7:0] trs [6] = '{8'hFF, 8'hFF, 8'h0F, 8'h00, 8'hFF, 8'h00};

  // ==========================================================
  // design and pads
  iopc_top i_dut (
    .i_mclk(i_mclk), .i_rstn(i_rstn), .i_ioc_wr(ioc_wr), .i_ioc_rd(ioc_rd),
    .i_ioc_addr(addr), .i_ioc_wdata(wdata), .o_ioc_rdata(rdata),
    .i_tmode_wr(tm_wr), .i_tmode_wdata(wdata), .i_isr_wr(isr_wr),
    .i_isr_wdata(wdata), .i_pb_pins(pins), .i_pb_dout(dout),
    .o_pa_dir(pa_dir), .o_pb_dir(pb_dir), .o_pb_oe(pb_oe),
    .o_pullhigh_n_a4(ph4), .o_pullhigh_n_a6(ph6), .o_pullhigh_n_a7(ph7),
    .o_pulldown_n_a5(pd5), .o_pa_pulldown_n(pad_n),
    .o_pb_pulldown_n(pbd_n), .o_pb_opendrain_en(od),
    .o_ext_edge_select(eds), .o_ext_irq_pin_select(eps),
    .o_isr_flags(flags), .o_irq_req(irq));
  iopc_pin_model i_pins (
    .i_mclk(i_mclk), .i_oe(pb_oe), .i_dout(dout), .i_pd_n(pbd_n),
    .i_ext_en(8'hFF), .i_ext_val(ext_val), .o_pins(pins));

  // 40 MHz instruction clock
  initial begin
    forever #12.5 i_mclk = ~i_mclk;
  end

  // ==========================================================
  // access tasks
  task automatic chk(input string nm, input logic [7:0] e, g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // k selects the strobe: 0 io-control, 1 timer mode, 2 status
  task automatic wr(input int k, input logic [7:0] a, d);
    @(posedge i_mclk);
    addr   <= a;
    wdata  <= d;
    ioc_wr <= (k == 0);
    tm_wr  <= (k == 1);
    isr_wr <= (k == 2);
    @(posedge i_mclk);
    ioc_wr <= 1'h0;
    tm_wr  <= 1'h0;
    isr_wr <= 1'h0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, e, input string nm);
    @(posedge i_mclk);
    addr   <= a;
    ioc_rd <= 1'h1;
    @(posedge i_mclk);
    ioc_rd <= 1'h0;
    @(posedge i_mclk);
    #1;
    chk(nm, e, rdata);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  task automatic pin(input logic [7:0] v);
    @(posedge i_mclk);
    ext_val <= v;
    #1;
  endtask
  // flags may take a few cycles through the pad model and flag registers
  task automatic wait_flags(input logic [7:0] e);
    int n;
    n = 0;
    while (flags !== e && n < 8) begin
      @(posedge i_mclk);
      #1;
      n++;
    end
    chk("flags", e, flags);
    if (flags !== e) begin
      report_and_stop();
    end
  endtask
  // pad outputs that mirror each table register; offset F9 has none
  function automatic logic [7:0] view(input int i);
    case (i)
      0: return pa_dir;
      1: return pb_dir;
      2: return {4'h0, pd5, ph7, ph6, ph4};
      4: return {pbd_n, pad_n};
      default: return od;
    endcase
  endfunction
  task automatic chk_regs(input logic [7:0] e [6]);
    for (int i = 0; i < 6; i++) begin
      if (i != 3) chk("pad view", e[i], view(i));
      rd(ta[i], e[i], "readback");
    end
  endtask

  // ==========================================================
  // main sequence
  initial begin
    repeat (10) @(posedge i_mclk);
    i_rstn <= 1'h1;
    #1;
    chk("irq", 8'h00, {7'h0, irq});
    chk("flags", 8'h00, flags);
    chk_regs(trs);
    $display("test reset values done");
    for (int i = 0; i < 6; i++) begin
      wr(0, ta[i], td[i]);
      if (i != 3) chk("pad view", tr[i], view(i));
    end
    wr(0, 8'hF7, 8'h55);
    rd(8'hF7, 8'h00, "unmapped");
    chk_regs(tr);
    $display("test register map done");
    @(posedge i_mclk);
    dout <= 8'hAA;
    wr(0, 8'hF6, 8'h00);
    wr(0, 8'hFC, 8'h0F);
    idle(2);
    chk("pad enable", 8'hF5, pb_oe);
    wr(0, 8'hFE, 8'h40);
    idle(2);
    chk("pad enable", 8'hF4, pb_oe);
    chk("pins", 8'hA0, pins);
    chk("pin select", 8'h01, {7'h0, eps});
    rd(8'hFE, 8'h40, "pin select read");
    wr(0, 8'hF6, 8'hFF);
    wr(0, 8'hFC, 8'h00);
    $display("test pad drive done");
    wr(0, 8'hF9, 8'h04);
    wr(0, 8'hFF, 8'h02);
    rd(8'hFF, 8'h02, "mask read");
    idle(3);
    wr(2, 8'h00, 8'hF9);
    chk("flags", 8'h00, flags);
    pin(8'h08);
    idle(6);
    chk("flags", 8'h00, flags);
    pin(8'h0C);
    wait_flags(8'h02);
    chk("irq", 8'h01, {7'h0, irq});
    idle(4);
    chk("flags", 8'h02, flags);
    // clear lands on the same edge as a new change event
    pin(8'h08);
    wr(2, 8'h00, 8'hFD);
    chk("flags", 8'h02, flags);
    pin(8'h0C);
    idle(3);
    wr(2, 8'h00, 8'hFD);
    chk("flags", 8'h00, flags);
    $display("test change flag done");
    wr(0, 8'hFF, 8'h04);
    wr(1, 8'h00, 8'h80);
    chk("edge select", 8'h01, {7'h0, eds});
    pin(8'h0D);
    wait_flags(8'h04);
    chk("irq", 8'h01, {7'h0, irq});
    wr(2, 8'h00, 8'hFB);
    pin(8'h0C);
    idle(6);
    chk("flags", 8'h00, flags);
    wr(1, 8'h00, 8'h00);
    chk("edge select", 8'h00, {7'h0, eds});
    pin(8'h0D);
    idle(6);
    chk("flags", 8'h00, flags);
    pin(8'h0C);
    wait_flags(8'h04);
    wr(0, 8'hFF, 8'h00);
    idle(2);
    chk("irq", 8'h00, {7'h0, irq});
    $display("test external pin done");
    report_and_stop();
  end
endmodule
